/* File: hdl/lvs_pkg.sv */
// types shared by the parallel-to-lvds serializer
package lvs_pkg;

    // configuration select code {cfg_sel_hi, cfg_sel_lo}
    typedef enum logic [1:0] {
        LVS_ONE_IN_ONE_OUT = 2'b00,
        LVS_ONE_IN_TWO_OUT = 2'b01,
        LVS_TWO_IN_TWO_OUT = 2'b10,
        LVS_CFG_RESERVED   = 2'b11
    } lvs_mode_t;

    // power state, gray coded
    typedef enum logic [1:0] {
        LVS_PWR_SLEEP = 2'b00,
        LVS_PWR_LOCK  = 2'b01,
        LVS_PWR_RUN   = 2'b11,
        LVS_PWR_IDLE  = 2'b10
    } lvs_pwr_t;

    // delay-line entry: a word per bank, load tag
    typedef struct packed {
        logic        tag;
        logic [27:0] b_word;
        logic [27:0] a_word;
    } lvs_pair_t;

    // lane drive control of one bank
    typedef struct packed {
        logic [4:0] on;
        logic [4:0] oe_n;
    } lvs_lane_ctl_t;

endpackage

/* File: hdl/lvs_regs.svh */
// constants of the lvds serializer core
`ifndef LVS_REGS_SVH
`define LVS_REGS_SVH

// register byte offsets
`define LVS_CTRL_OFS        8'h00
`define LVS_STAT_OFS        8'h04
`define LVS_CTRL_RST        32'h0000_0000

// control fields
`define LVS_CTRL_SLEEP_BIT  0

// status fields
`define LVS_STAT_MODE_LSB   0
`define LVS_STAT_CLK_BIT    2
`define LVS_STAT_LOCK_BIT   3
`define LVS_STAT_IDLE_BIT   4
`define LVS_STAT_PHASE_BIT  5
`define LVS_STAT_SWING_BIT  6
`define LVS_STAT_DEPTH_BIT  7

// axi responses
`define LVS_RESP_OKAY       2'b00
`define LVS_RESP_SLVERR     2'b10

// sync and valid bit positions in a pixel word
`define LVS_LS_POS          18
`define LVS_FS_POS          19
`define LVS_PV_POS          20
`define LVS_LANE3_LSB       21

// frame: 7 bits a lane, clock high 4 of 7 (57:43)
`define LVS_FRAME_BITS      7
`define LVS_CLK_PATTERN     7'h63

// timing
`define LVS_ACLK_NS         25
`define LVS_LOCK_NS         1000000
`define LVS_LOSS_NS         1000

// delay-line depth and taps (pixel edges of latency)
`define LVS_DLY_DEPTH       8
`define LVS_TAP_DIRECT      1
`define LVS_TAP_SPLIT       7

`endif

/* File: hdl/lvs_ser.sv */
// one lvds bank: 7-bit lane shifters, registered drive
`timescale 1ns/1ps
`default_nettype none
module lvs_ser #(
    parameter int LANES = 5,
    parameter int BITS  = 7
) (
    input  wire logic                  aclk,      // system clock
    input  wire logic                  aresetn,   // sync reset, active low
    input  wire logic                  load,      // frame start pulse
    input  wire logic                  slow,      // one bit per two clocks
    input  wire logic [LANES*BITS-1:0] word,      // frame bits, lane-major
    input  wire logic [LANES-1:0]      lane_on,   // lane drives data
    input  wire logic [LANES-1:0]      oe_n_in,   // lane released
    output logic      [LANES-1:0]      lane_q,    // serial bit per lane
    output logic      [LANES-1:0]      lane_oe_n  // low while driven
);
    logic div_r;
    logic step;

    // half-rate bit pacing; realigned at every frame start
    always_ff @(posedge aclk) begin
        if (!aresetn || load) begin
            div_r <= 1'b0;
        end else begin
            div_r <= ~div_r;
        end
    end

    assign step = ~slow | div_r;

    for (genvar i = 0; i < LANES; i++) begin : g_lane
        logic [BITS-1:0] sh_r;

        // msb first; last bit repeats if the next frame is late
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sh_r <= '0;
            end else if (load) begin
                sh_r <= word[i*BITS +: BITS];
            end else if (step) begin
                sh_r <= {sh_r[BITS-2:0], sh_r[0]};
            end
        end

        // a lane not powered sits low, whether released or not
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                lane_q[i]    <= 1'b0;
                lane_oe_n[i] <= 1'b0;
            end else begin
                lane_q[i]    <= lane_on[i] & sh_r[BITS-1];
                lane_oe_n[i] <= oe_n_in[i];
            end
        end
    end
endmodule
`default_nettype wire

/* File: hdl/lvs_sync.sv */
// two-flop synchronizer for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module lvs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             aclk,    // system clock
    input  wire logic             aresetn, // sync reset, active low
    input  wire logic [WIDTH-1:0] d,       // asynchronous pin levels
    output logic      [WIDTH-1:0] q        // synchronized levels
);
    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/lvs_top.sv */
// pixel bus to lvds serializer core, axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "lvs_regs.svh"
module lvs_top #(
    parameter int LOCK_CYC = `LVS_LOCK_NS / `LVS_ACLK_NS,
    parameter int LOSS_CYC = (`LVS_LOSS_NS + `LVS_ACLK_NS - 1)
                             / `LVS_ACLK_NS
) (
    input  wire logic        aclk,              // 40 MHz system clock
    input  wire logic        aresetn,           // sync reset, active low
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,      // write address
    input  wire logic        s_axi_awvalid,     // write address valid
    output logic             s_axi_awready,     // write address ready
    input  wire logic [31:0] s_axi_wdata,       // write data
    input  wire logic [3:0]  s_axi_wstrb,       // write byte strobes
    input  wire logic        s_axi_wvalid,      // write data valid
    output logic             s_axi_wready,      // write data ready
    output logic [1:0]       s_axi_bresp,       // write response
    output logic             s_axi_bvalid,      // write response valid
    input  wire logic        s_axi_bready,      // write response ready
    input  wire logic [7:0]  s_axi_araddr,      // read address
    input  wire logic        s_axi_arvalid,     // read address valid
    output logic             s_axi_arready,     // read address ready
    output logic [31:0]      s_axi_rdata,       // read data
    output logic [1:0]       s_axi_rresp,       // read response
    output logic             s_axi_rvalid,      // read data valid
    input  wire logic        s_axi_rready,      // read data ready
    // parallel pixel pins
    input  wire logic        pix_clk,           // host pixel clock pin
    input  wire logic [27:0] port_a_data,       // port a pixel bits
    input  wire logic [27:0] port_b_data,       // port b pixel bits
    input  wire logic        line_sync,         // line sync pin
    input  wire logic        frame_sync,        // frame sync pin
    input  wire logic        pixel_valid_flag,  // pixel valid pin
    // configuration pins
    input  wire logic        cfg_sel_hi,        // config select hi
    input  wire logic        cfg_sel_lo,        // config select lo
    input  wire logic        color_depth_sel_pin, // 1 = 18-bit colour
    input  wire logic        latch_edge_sel,    // 1 rising, 0 falling
    input  wire logic        sleep_n,           // 0 = sleep
    input  wire logic        swing_sel,         // 1 = high swing
    // lvds side
    output logic [3:0]       bank_a_lane,       // bank a data lanes
    output logic [3:0]       bank_a_lane_oe_n,  // bank a lanes released
    output logic             bank_a_clock_lane, // bank a clock lane
    output logic             bank_a_clock_oe_n, // bank a clock released
    output logic [3:0]       bank_b_lane,       // bank b data lanes
    output logic [3:0]       bank_b_lane_oe_n,  // bank b lanes released
    output logic             bank_b_clock_lane, // bank b clock lane
    output logic             bank_b_clock_oe_n, // bank b clock released
    output logic             swing_hi,          // high output swing
    output logic             pll_locked         // serializer ready
);
    import lvs_pkg::*;

    localparam int PINS = 66;
    localparam int LW = $clog2(LOCK_CYC + 1);
    localparam int SW = $clog2(LOSS_CYC + 1);

    logic [PINS-1:0] pin_s;
    logic [27:0]     a_s, b_s;
    logic            pclk_s, ls_s, fs_s, pv_s;
    logic            depth18_s, edge_sel_s, sleep_n_s, swing_s;
    lvs_mode_t       mode;
    logic            pclk_d_r, rise, fall, lat_edge;
    logic [SW-1:0]   loss_cnt_r;
    logic            clk_present_r;
    lvs_pwr_t        pwr_r;
    logic [LW-1:0]   lock_cnt_r;
    logic            run, awake, dp_rst;
    logic [31:0]     ctrl_r;
    logic            phase_r, pv_prev_r;
    logic [27:0]     odd_r, word_a, word_b;
    lvs_pair_t       dly_r [`LVS_DLY_DEPTH];
    lvs_pair_t       push, tapped;
    logic            split, load;
    lvs_lane_ctl_t   ctl_a, ctl_b;
    logic            aw_got_r, w_got_r;
    logic [7:0]      awaddr_r;
    logic [31:0]     wdata_r;
    logic [3:0]      wstrb_r;
    logic [31:0]     status;

    // every pin level crosses into aclk before use
    lvs_sync #(
        .WIDTH (PINS)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({pix_clk, port_a_data, port_b_data, line_sync,
                   frame_sync, pixel_valid_flag, cfg_sel_hi, cfg_sel_lo,
                   color_depth_sel_pin, latch_edge_sel, sleep_n,
                   swing_sel}),
        .q       (pin_s)
    );

    assign {pclk_s, a_s, b_s, ls_s, fs_s, pv_s} = pin_s[65:6];
    assign mode       = lvs_mode_t'(pin_s[5:4]);
    assign depth18_s  = pin_s[3];
    assign edge_sel_s = pin_s[2];
    assign sleep_n_s  = pin_s[1];
    assign swing_s    = pin_s[0];

    // pixel-clock edges seen by aclk
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pclk_d_r <= 1'b0;
        end else begin
            pclk_d_r <= pclk_s;
        end
    end

    assign rise     = pclk_s & ~pclk_d_r;
    assign fall     = ~pclk_s & pclk_d_r;
    assign lat_edge = edge_sel_s ? rise : fall;

    // clock loss: no edge of either sense for LOSS_CYC cycles
    always_ff @(posedge aclk) begin
        if (!aresetn || rise || fall) begin
            loss_cnt_r    <= '0;
            clk_present_r <= aresetn;
        end else if (loss_cnt_r != SW'(LOSS_CYC)) begin
            loss_cnt_r <= loss_cnt_r + 1'b1;
        end else begin
            clk_present_r <= 1'b0;
        end
    end

    // sleep pin or soft sleep bit resets the datapath
    assign awake  = sleep_n_s & ~ctrl_r[`LVS_CTRL_SLEEP_BIT];
    assign dp_rst = ~aresetn | ~awake;

    // power state: sleep, lock wait, run, idle
    always_ff @(posedge aclk) begin
        if (dp_rst) begin
            pwr_r <= LVS_PWR_SLEEP;
        end else begin
            case (pwr_r)
                LVS_PWR_SLEEP: begin
                    pwr_r <= LVS_PWR_LOCK;
                end
                LVS_PWR_LOCK: begin
                    if (!clk_present_r) begin
                        pwr_r <= LVS_PWR_IDLE;
                    end else if (lock_cnt_r == LW'(LOCK_CYC - 1)) begin
                        pwr_r <= LVS_PWR_RUN;
                    end
                end
                LVS_PWR_RUN: begin
                    if (!clk_present_r) begin
                        pwr_r <= LVS_PWR_IDLE;
                    end
                end
                LVS_PWR_IDLE: begin
                    if (clk_present_r) begin
                        pwr_r <= LVS_PWR_LOCK;
                    end
                end
                default: begin
                    pwr_r <= LVS_PWR_SLEEP;
                end
            endcase
        end
    end

    // lock timer counts only in the lock wait
    always_ff @(posedge aclk) begin
        if (dp_rst || pwr_r != LVS_PWR_LOCK) begin
            lock_cnt_r <= '0;
        end else begin
            lock_cnt_r <= lock_cnt_r + 1'b1;
        end
    end

    assign run   = (pwr_r == LVS_PWR_RUN);
    assign split = (mode == LVS_ONE_IN_TWO_OUT);

    // pixel words: sync and valid in each, lane 3 zeroed at 18-bit depth
    always_comb begin
        word_a = a_s;
        word_b = b_s;
        word_a[`LVS_LS_POS] = ls_s;
        word_a[`LVS_FS_POS] = fs_s;
        word_a[`LVS_PV_POS] = pv_s;
        word_b[`LVS_LS_POS] = ls_s;
        word_b[`LVS_FS_POS] = fs_s;
        word_b[`LVS_PV_POS] = pv_s;
        if (depth18_s) begin
            word_a[27:`LVS_LANE3_LSB] = '0;
            word_b[27:`LVS_LANE3_LSB] = '0;
        end
    end

    // split phase: a valid rise restarts on an odd pixel
    always_ff @(posedge aclk) begin
        if (dp_rst) begin
            phase_r   <= 1'b0;
            pv_prev_r <= 1'b0;
            odd_r     <= '0;
        end else if (lat_edge) begin
            pv_prev_r <= pv_s;
            if ((pv_s && !pv_prev_r) || !phase_r) begin
                odd_r   <= word_a;
                phase_r <= 1'b1;
            end else begin
                phase_r <= 1'b0;
            end
        end
    end

    // entry per latch edge; tag marks a frame to send
    always_comb begin
        push = '0;
        if (split) begin
            push.tag    = phase_r && !(pv_s && !pv_prev_r);
            push.a_word = odd_r;
            push.b_word = word_a;
        end else begin
            push.tag    = 1'b1;
            push.a_word = word_a;
            push.b_word = word_b;
        end
    end

    // latency line stepped by pixel edges; pairs enter late
    always_ff @(posedge aclk) begin
        if (dp_rst) begin
            for (int i = 0; i < `LVS_DLY_DEPTH; i++) begin
                dly_r[i] <= '0;
            end
        end else if (lat_edge) begin
            dly_r[0] <= push;
            for (int i = 1; i < `LVS_DLY_DEPTH; i++) begin
                dly_r[i] <= dly_r[i-1];
            end
        end
    end

    // tap gives two pixel periods direct, eight split
    assign tapped = split ? dly_r[`LVS_TAP_SPLIT]
                          : dly_r[`LVS_TAP_DIRECT];
    assign load   = lat_edge & tapped.tag;

    // lane control: mode power-down beats depth release
    always_comb begin
        logic a_used;
        logic b_used;
        a_used = run && (mode != LVS_CFG_RESERVED);
        b_used = run && (mode != LVS_CFG_RESERVED)
                     && (mode != LVS_ONE_IN_ONE_OUT);
        ctl_a.on   = {a_used, a_used & ~depth18_s, {3{a_used}}};
        ctl_a.oe_n = {1'b0, a_used & depth18_s, 3'b000};
        ctl_b.on   = {b_used, b_used & ~depth18_s, {3{b_used}}};
        ctl_b.oe_n = {1'b0, b_used & depth18_s, 3'b000};
    end

    // bank a: lane 4 is the clock lane pattern
    lvs_ser #(
        .LANES (5),
        .BITS  (`LVS_FRAME_BITS)
    ) u_ser_a (
        .aclk      (aclk),
        .aresetn   (~dp_rst),
        .load      (load),
        .slow      (split),
        .word      ({`LVS_CLK_PATTERN, tapped.a_word}),
        .lane_on   (ctl_a.on),
        .oe_n_in   (ctl_a.oe_n),
        .lane_q    ({bank_a_clock_lane, bank_a_lane}),
        .lane_oe_n ({bank_a_clock_oe_n, bank_a_lane_oe_n})
    );

    // bank b: same framing, so both clock lanes stay in step
    lvs_ser #(
        .LANES (5),
        .BITS  (`LVS_FRAME_BITS)
    ) u_ser_b (
        .aclk      (aclk),
        .aresetn   (~dp_rst),
        .load      (load),
        .slow      (split),
        .word      ({`LVS_CLK_PATTERN, tapped.b_word}),
        .lane_on   (ctl_b.on),
        .oe_n_in   (ctl_b.oe_n),
        .lane_q    ({bank_b_clock_lane, bank_b_lane}),
        .lane_oe_n ({bank_b_clock_oe_n, bank_b_lane_oe_n})
    );

    // swing and lock flags; lock drops as soon as sleep is asked
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swing_hi   <= 1'b0;
            pll_locked <= 1'b0;
        end else begin
            swing_hi   <= swing_s;
            pll_locked <= run & awake;
        end
    end

    // axi write: address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            awaddr_r      <= '0;
            wdata_r       <= '0;
            wstrb_r       <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `LVS_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_got_r & ~s_axi_bvalid
                           & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready  <= ~w_got_r & ~s_axi_bvalid
                           & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (aw_got_r && w_got_r && !s_axi_bvalid) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_r == `LVS_CTRL_OFS ||
                                 awaddr_r == `LVS_STAT_OFS)
                              ? `LVS_RESP_OKAY : `LVS_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control: only byte 0 holds bits; status is read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `LVS_CTRL_RST;
        end else if (aw_got_r && w_got_r && !s_axi_bvalid
                     && awaddr_r == `LVS_CTRL_OFS && wstrb_r[0]) begin
            ctrl_r[`LVS_CTRL_SLEEP_BIT] <= wdata_r[`LVS_CTRL_SLEEP_BIT];
        end
    end

    // status view of own state
    always_comb begin
        status = '0;
        status[`LVS_STAT_MODE_LSB +: 2] = mode;
        status[`LVS_STAT_CLK_BIT]   = clk_present_r;
        status[`LVS_STAT_LOCK_BIT]  = run;
        status[`LVS_STAT_IDLE_BIT]  = (pwr_r == LVS_PWR_IDLE);
        status[`LVS_STAT_PHASE_BIT] = phase_r;
        status[`LVS_STAT_SWING_BIT] = swing_s;
        status[`LVS_STAT_DEPTH_BIT] = depth18_s;
    end

    // axi read: answered the cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `LVS_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid
                           & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `LVS_RESP_OKAY;
                case (s_axi_araddr)
                    `LVS_CTRL_OFS: begin
                        s_axi_rdata <= ctrl_r;
                    end
                    `LVS_STAT_OFS: begin
                        s_axi_rdata <= status;
                    end
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= `LVS_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/lvs_chk.sv */
// pin checker of the serializer core
`timescale 1ns/1ps
`default_nettype none
module lvs_chk (
    input wire logic       aclk,                // clock
    input wire logic       aresetn,             // reset
    input wire logic       sleep_n,             // sleep pin
    input wire logic       cfg_sel_hi,          // mode hi
    input wire logic       cfg_sel_lo,          // mode lo
    input wire logic       color_depth_sel_pin, // 18-bit
    input wire logic       swing_sel,           // swing pin
    input wire logic       swing_hi,            // swing out
    input wire logic       pll_locked,          // locked
    input wire logic [3:0] bank_a_lane,         // a lanes
    input wire logic [3:0] bank_a_lane_oe_n,    // a released
    input wire logic       bank_a_clock_lane,   // a clock
    input wire logic [3:0] bank_b_lane,         // b lanes
    input wire logic [3:0] bank_b_lane_oe_n     // b released
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // clock lane low run; lost lock may end it
    sequence gap3_s;
        (!bank_a_clock_lane) [*3] ##1 (bank_a_clock_lane || !pll_locked);
    endsequence
    sequence gap6_s;
        (!bank_a_clock_lane) [*6] ##1 (bank_a_clock_lane || !pll_locked);
    endsequence
    // pins pass two flops, so levels are held first
    sleep_down_a: assert property (
        !sleep_n [*8] |-> !pll_locked && bank_a_lane_oe_n == 4'h0)
        else $error("lanes live in sleep");
    unlocked_low_a: assert property (
        !pll_locked [*4] |-> bank_a_lane == 4'h0 && !bank_a_clock_lane)
        else $error("lanes live unlocked");
    reserved_off_a: assert property (
        (cfg_sel_hi && cfg_sel_lo) [*8] |-> bank_a_lane_oe_n == 4'h0)
        else $error("lanes live in reserved");
    single_b_off_a: assert property (
        (!cfg_sel_hi && !cfg_sel_lo) [*8] |-> bank_b_lane == 4'h0
            && bank_b_lane_oe_n == 4'h0)
        else $error("bank b live in single");
    depth_off_a: assert property (
        (pll_locked && color_depth_sel_pin && cfg_sel_hi && !cfg_sel_lo) [*8]
            |-> bank_a_lane_oe_n[3] && bank_b_lane_oe_n[3] && !bank_a_lane[3])
        else $error("fourth lane driven");
    swing_follow_a: assert property (
        $stable(swing_sel) [*6] |-> swing_hi == swing_sel)
        else $error("swing mismatch");
    direct_clk_a: assert property (
        disable iff (!aresetn || !sleep_n)
        $fell(bank_a_clock_lane) && !cfg_sel_lo |-> gap3_s)
        else $error("clock low run wrong");
    split_clk_a: assert property (
        disable iff (!aresetn || !sleep_n)
        $fell(bank_a_clock_lane) && cfg_sel_lo && !cfg_sel_hi |-> gap6_s)
        else $error("split clock run wrong");
endmodule
`default_nettype wire

/* File: test/lvs_rx.sv */
// deserializer model: rebuilds each full-rate frame of one lvds bank
`timescale 1ns/1ps
`default_nettype none
module lvs_rx (
    input  wire logic        aclk,     // clock
    input  wire logic [3:0]  lane,     // data lanes
    input  wire logic        clk_lane, // clock lane
    output logic      [27:0] word,     // last frame
    output logic             got       // frame complete
);
    logic [6:0] hist [5];
    // one bit a cycle; first bit of a frame ends at the top
    always_ff @(posedge aclk) begin
        for (int k = 0; k < 4; k++)
            hist[k] <= {hist[k][5:0], lane[k]};
        hist[4] <= {hist[4][5:0], clk_lane};
    end
    // frame whole once the clock lane shows its shape
    assign got  = (hist[4] == 7'h63);
    assign word = {hist[3], hist[2], hist[1], hist[0]};
endmodule
`default_nettype wire

/* File: test/lvs_top_bench.sv */
// self-checking bench of the core
`timescale 1ns/1ps
`default_nettype none
`define CK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
    $display("wrong value at %0t got %h exp %h", $time, a, e); end end
module lvs_top_bench;
    import lvs_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, pix_clk = 1'b0, pix_run = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf, bank_a_lane, bank_a_lane_oe_n;
    logic [3:0]  bank_b_lane, bank_b_lane_oe_n;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
    logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [27:0] port_a_data = 28'h9a5c3e1, port_b_data = 28'h36a5a97;
    logic [27:0] word_a, word_b;
    logic        line_sync = 1'b0, frame_sync = 1'b1, pixel_valid_flag = 1'b1;
    logic        cfg_sel_hi = 1'b1, cfg_sel_lo = 1'b0, latch_edge_sel = 1'b1;
    logic        color_depth_sel_pin = 1'b0, sleep_n = 1'b0, swing_sel = 1'b0;
    logic        bank_a_clock_lane, bank_a_clock_oe_n, bank_b_clock_lane;
    logic        bank_b_clock_oe_n, swing_hi, pll_locked, got_a, got_b;
    int          err_count = 0, compares = 0;
    lvs_top #(.LOCK_CYC(20)) dut_u (.*);
    lvs_rx rxa_u (.aclk, .lane(bank_a_lane), .clk_lane(bank_a_clock_lane),
                  .word(word_a), .got(got_a));
    lvs_rx rxb_u (.aclk, .lane(bank_b_lane), .clk_lane(bank_b_clock_lane),
                  .word(word_b), .got(got_b));
    // pixel clock stands low while stopped
    initial forever #12.5 aclk = ~aclk;
    initial begin
        #7;
        forever #100 if (pix_run || pix_clk) pix_clk = ~pix_clk;
    end
    task automatic summarize;
        $display("%0d mismatches in %0d compares", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic fin(input string s);
        $display("test %s done", s);
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] e);
        logic pa = 1'b1, pw = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa || pw) begin
            @(posedge aclk);
            if (pa && s_axi_awready) begin
                pa = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (pw && s_axi_wready) begin
                pw = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        s_axi_bready <= 1'b0;
        `CK(s_axi_bresp, e)
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        `CK({s_axi_rdata, s_axi_rresp}, {d, e})
    endtask
    task automatic wake;
        @(posedge aclk);
        sleep_n <= 1'b1;
        do @(posedge aclk); while (pll_locked !== 1'b1);
        repeat (60) @(posedge aclk);
    endtask
    // mode and depth change only while asleep
    task automatic nap(input lvs_mode_t m, input logic d);
        @(posedge aclk);
        sleep_n <= 1'b0;
        repeat (8) @(posedge aclk);
        `CK(pll_locked, 1'b0)
        {cfg_sel_hi, cfg_sel_lo} <= m;
        color_depth_sel_pin <= d;
    endtask
    function automatic logic [27:0] fw(input logic [27:0] w, input logic d);
        return {d ? 7'h00 : w[27:21], pixel_valid_flag, frame_sync,
                line_sync, w[17:0]};
    endfunction
    task automatic frames(input logic d, input logic cb);
        repeat (3) begin
            do @(posedge aclk); while (got_a !== 1'b1);
            `CK(word_a, fw(port_a_data, d))
            if (cb) `CK(word_b, fw(port_b_data, d))
        end
    endtask
    initial begin
        #2000000;
        err_count++;
        summarize;
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axr(8'h00, 32'h0, 2'b00);
        axr(8'h08, 32'h0, 2'b10);
        axw(8'h08, 32'h1, 2'b10);
        fin("regs");
        wake;
        frames(1'b0, 1'b1);
        fin("dual");
        axw(8'h00, 32'h1, 2'b00);
        repeat (8) @(posedge aclk);
        `CK(pll_locked, 1'b0)
        axr(8'h00, 32'h1, 2'b00);
        axw(8'h00, 32'h0, 2'b00);
        wake;
        fin("soft sleep");
        nap(LVS_TWO_IN_TWO_OUT, 1'b1);
        latch_edge_sel <= 1'b0;
        wake;
        frames(1'b1, 1'b1);
        fin("dual 18-bit");
        nap(LVS_ONE_IN_ONE_OUT, 1'b1);
        wake;
        frames(1'b1, 1'b0);
        `CK(bank_b_lane_oe_n, 4'h0)
        fin("single");
        nap(LVS_ONE_IN_TWO_OUT, 1'b0);
        wake;
        pix_run <= 1'b0;
        repeat (80) @(posedge aclk);
        `CK(pll_locked, 1'b0)
        pix_run <= 1'b1;
        wake;
        swing_sel <= 1'b1;
        repeat (8) @(posedge aclk);
        `CK(swing_hi, 1'b1)
        fin("split");
        nap(LVS_CFG_RESERVED, 1'b0);
        sleep_n <= 1'b1;
        repeat (60) @(posedge aclk);
        `CK({bank_a_lane_oe_n, bank_b_lane_oe_n}, 8'h00)
        fin("reserved");
        summarize;
    end
endmodule
bind lvs_top lvs_chk chk_u (.*);
`default_nettype wire
